// file: hw/sac_serial_channel.sv
// Full-duplex serial channel with APB registers, interrupt and DMA ready lines.
// Assumes rxClk, txClk and serialIn are synchronous to mclk and much slower.
//
// Overview of operation
// - One full-duplex channel, double-buffered, separate clocks, status and data.
// - Normal and error interrupts per direction; ready lines serve DMA when masked.
// - Async or sync format independent of clock mode; div1 samples every rising edge.
// - Divide-by-16 mode samples each bit at its middle.
// - Valid transition resets phase; checking off below four; sample at eight.
// - Async word length five to eight, one, one and half (two in div1), two stops.
// - Parity odd, even or none; short characters zero-filled, parity above.
// - Async receiver waits for a zero bit before shifting data.
// - Div16 start must stay low three edges, then no rise for eight more.
// - Sync receiver hunts for the sync character before taking data.
// - Sync transmitter sends the sync character during underrun.
// - Optionally strip received sync characters from the buffer.
// - Sync character bits above the word length and parity bit are forced to zero.
// - Sync word one bit longer with parity; device computes it at eight.
// - Shift register assembles word, moves to buffer once read, interrupts.
// - Data register read returns buffer, clears full, allows next transfer.
// - Status latched with each buffer transfer, held until data is read.
//
// Decided for this implementation: the register offsets and the APB slave port.
`timescale 1ns/1ps
module sac_serial_channel
    import sac_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        rstn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        rxClk,
    input  wire logic        txClk,
    input  wire logic        serialIn,
    output logic             serialOut,
    output logic             rxReady,
    output logic             txReady,
    output logic             irq
);
    typedef struct packed {
        sac_cfg_t      cfg;
        logic [7:0]    syncChr;
        logic [3:0]    intMask;
        logic [3:0]    intSt;
        logic [31:0]   rdData;
        logic          rdErr;
        sac_rx_state_t rxSt;
        logic [3:0]    rxPh;
        logic [3:0]    rxCnt;
        logic [8:0]    rxSh;
        logic          lastSi;
        logic          synced;
        logic [7:0]    asmChr;
        logic          asmPe;
        logic          asmFe;
        logic          asmSm;
        logic          asmValid;
        logic          ovPend;
        logic [7:0]    rxBuf;
        logic          bufFull;
        logic          stPe;
        logic          stFe;
        logic          stOv;
        logic          stSm;
        sac_tx_state_t txSt;
        logic [4:0]    txPh;
        logic [3:0]    txCnt;
        logic [8:0]    txSh;
        logic [7:0]    txBuf;
        logic          txFull;
        logic          txUnder;
        logic          txOut;
    } sac_state_t;

    sac_state_t s;
    sac_state_t next_s;

    logic       rxTick;
    logic       txTick;
    logic       rxParCalc;
    logic       txParCalc;
    logic       syncParCalc;
    logic [3:0] wlenN;
    logic [3:0] nBits;
    logic [7:0] lenMask;
    logic       syncMode;
    logic       setupRd;
    logic       accWr;
    logic       accRd;
    logic       rxStb;
    logic       resync;
    logic       deliver;
    logic       huntHit;
    logic       txBitEnd;
    logic [4:0] txLast;
    logic [3:0] txIdx;
    logic [8:0] txFrame;
    logic [8:0] syncFrame;
    logic [3:0] intSet;
    logic [3:0] intClr;

    // ----------------------------------------
    // Clock pins and parity helpers
    // ----------------------------------------
    // separate bit clocks
    sac_edge uRxEdge (
        .mclk  (mclk),
        .rstn  (rstn),
        .level (rxClk),
        .rise  (rxTick)
    );

    sac_edge uTxEdge (
        .mclk  (mclk),
        .rstn  (rstn),
        .level (txClk),
        .rise  (txTick)
    );

    sac_parity #(.W(8)) uRxPar (
        .data (s.rxSh[7:0]),
        .len  (wlenN),
        .even (s.cfg.even),
        .par  (rxParCalc)
    );

    sac_parity #(.W(8)) uTxPar (
        .data (s.txBuf),
        .len  (wlenN),
        .even (s.cfg.even),
        .par  (txParCalc)
    );

    sac_parity #(.W(8)) uSyncPar (
        .data (s.syncChr),
        .len  (wlenN),
        .even (s.cfg.even),
        .par  (syncParCalc)
    );

    // ----------------------------------------
    // Next-state logic
    // ----------------------------------------
    always_comb begin
        next_s   = s;
        intSet   = '0;
        intClr   = '0;
        // length code 0..3 gives eight down to five
        wlenN    = WLEN_MAX - {2'h0, s.cfg.wlen};
        nBits    = wlenN + {3'h0, s.cfg.parEn};
        syncMode = (s.cfg.stop == STOP_SYNC);
        for (int i = 0; i < 8; i++) begin
            lenMask[i] = (4'(i) < nBits);
        end
        setupRd  = psel & ~penable & ~pwrite;
        accWr    = psel & penable & pwrite;
        accRd    = psel & penable & ~pwrite;

        // Register read data is captured in the setup cycle
        if (setupRd) begin
            next_s.rdErr = 1'b0;
            case (paddr)
                ADDR_CTRL:    next_s.rdData = {22'h0, s.cfg};
                ADDR_SYNC:    next_s.rdData = {24'h0, s.syncChr};
                ADDR_RXSTAT:  next_s.rdData = {26'h0, s.synced, s.stSm, s.stOv,
                                               s.stFe, s.stPe, s.bufFull};
                ADDR_TXSTAT:  next_s.rdData = {29'h0, (s.txSt != TX_IDLE),
                                               s.txUnder, ~s.txFull};
                ADDR_DATA:    next_s.rdData = {24'h0, s.rxBuf};
                ADDR_INTSTAT: next_s.rdData = {28'h0, s.intSt};
                ADDR_INTMASK: next_s.rdData = {28'h0, s.intMask};
                default: begin
                    next_s.rdData = '0;
                    next_s.rdErr  = 1'b1;
                end
            endcase
        end
        if (accRd && paddr == ADDR_INTSTAT) begin
            intClr = s.intSt;
        end
        // data read frees the receive buffer
        if (accRd && paddr == ADDR_DATA) begin
            next_s.bufFull = 1'b0;
        end
        if (accWr) begin
            case (paddr)
                ADDR_CTRL:    next_s.cfg = pwdata[$bits(sac_cfg_t)-1:0];
                // unused sync bits cleared at write time
                ADDR_SYNC:    next_s.syncChr = pwdata[7:0] & lenMask;
                ADDR_INTMASK: next_s.intMask = pwdata[3:0];
                ADDR_DATA: begin
                    next_s.txBuf   = pwdata[7:0];
                    next_s.txFull  = 1'b1;
                    next_s.txUnder = 1'b0;
                end
                default: ;
            endcase
        end

        // ------------------------------------
        // Receiver
        // ------------------------------------
        // div1 every rise, div16 at mid-bit
        rxStb   = rxTick & (s.cfg.div16 ? (s.rxPh == RX_MID) : 1'b1);
        resync  = s.cfg.div16 & (s.rxPh >= RESYNC_MIN) & (serialIn != s.lastSi);
        deliver = 1'b0;
        huntHit = 1'b0;
        if (rxTick) begin
            next_s.lastSi = serialIn;
        end
        if (rxTick && s.rxSt != RX_START) begin
            next_s.rxPh = resync ? 4'h0 : s.rxPh + 4'h1;
        end
        if (!s.cfg.rxEn) begin
            next_s.rxSt   = RX_IDLE;
            next_s.synced = 1'b0;
            next_s.rxCnt  = '0;
            next_s.rxSh   = '0;
        end else if (rxTick) begin
            case (s.rxSt)
                RX_IDLE: begin
                    next_s.rxCnt = '0;
                    if (syncMode) begin
                        next_s.rxSt = RX_START;
                    end else if (!serialIn) begin
                        // only a zero bit starts a character
                        next_s.rxSh = '0;
                        next_s.rxSt = s.cfg.div16 ? RX_START : RX_DATA;
                        next_s.rxPh = 4'h1;
                    end
                end
                RX_START: begin
                    if (syncMode) begin
                        // slide a window until it equals the sync word
                        next_s.rxPh = resync ? 4'h0 : s.rxPh + 4'h1;
                        if (rxStb) begin
                            next_s.rxSh = s.rxSh >> 1;
                            next_s.rxSh[nBits - 4'h1] = serialIn;
                            huntHit = (next_s.rxSh[7:0] == s.syncChr) &&
                                      (!s.cfg.parEn || wlenN != WLEN_MAX ||
                                       next_s.rxSh[8] == syncParCalc);
                        end
                        if (huntHit) begin
                            next_s.synced = 1'b1;
                            next_s.rxSh   = '0;
                            next_s.rxSt   = RX_DATA;
                        end
                    end else if (serialIn && s.rxPh < START_ACCEPT) begin
                        // early rise rejects a false start
                        next_s.rxSt = RX_IDLE;
                    end else if (s.rxPh == PH16_LAST) begin
                        next_s.rxPh = 4'h0;
                        next_s.rxSt = RX_DATA;
                    end else begin
                        next_s.rxPh = s.rxPh + 4'h1;
                    end
                end
                RX_DATA: begin
                    if (rxStb) begin
                        // bits land at their index, parity above data
                        next_s.rxSh[s.rxCnt] = serialIn;
                        next_s.rxCnt = s.rxCnt + 4'h1;
                        if (s.rxCnt + 4'h1 == nBits) begin
                            if (syncMode) begin
                                deliver = 1'b1;
                            end else begin
                                next_s.rxSt = RX_STOP;
                            end
                        end
                    end
                end
                RX_STOP: begin
                    if (rxStb) begin
                        deliver     = 1'b1;
                        next_s.rxSt = RX_IDLE;
                    end
                end
                default: next_s.rxSt = RX_IDLE;
            endcase
        end
        // assembled word waits behind a full buffer
        if (deliver) begin
            // matching sync words may be dropped
            if (syncMode && s.cfg.strip && next_s.rxSh[7:0] == s.syncChr) begin
            end else if (s.asmValid) begin
                next_s.ovPend       = 1'b1;
                intSet[INT_RX_ERR] = 1'b1;
            end else begin
                next_s.asmValid = 1'b1;
                next_s.asmChr   = next_s.rxSh[7:0];
                next_s.asmPe    = s.cfg.parEn & (next_s.rxSh[wlenN] != rxParCalc);
                next_s.asmFe    = ~syncMode & ~serialIn;
                next_s.asmSm    = syncMode & (next_s.rxSh[7:0] == s.syncChr);
            end
            next_s.rxSh  = '0;
            next_s.rxCnt = '0;
        end
        if (s.asmValid && !s.bufFull) begin
            next_s.rxBuf    = s.asmChr;
            next_s.stPe     = s.asmPe;
            next_s.stFe     = s.asmFe;
            next_s.stOv     = s.ovPend;
            next_s.stSm     = s.asmSm;
            next_s.bufFull  = 1'b1;
            next_s.asmValid = 1'b0;
            next_s.ovPend   = deliver & s.asmValid;
            intSet[INT_RX_FULL] = 1'b1;
            intSet[INT_RX_ERR]  = intSet[INT_RX_ERR] | s.asmPe | s.asmFe | s.ovPend;
        end

        // ------------------------------------
        // Transmitter
        // ------------------------------------
        // stop length in sixteenths, 1.5 rounds to 2 in div1
        if (s.txSt == TX_STOP) begin
            if (s.cfg.div16) begin
                txLast = (s.cfg.stop == STOP_1)  ? TX_BIT_LAST16 :
                         (s.cfg.stop == STOP_15) ? TX_STOP15_16 : TX_STOP2_16;
            end else begin
                txLast = (s.cfg.stop == STOP_1) ? 5'h00 : TX_STOP2_1;
            end
        end else begin
            txLast = s.cfg.div16 ? TX_BIT_LAST16 : 5'h00;
        end
        txBitEnd = txTick & (s.txPh == txLast);
        txIdx    = s.txCnt + 4'h1;
        txFrame  = {1'b0, s.txBuf & lenMask};
        if (s.cfg.parEn) begin
            txFrame[wlenN] = txParCalc;
        end
        // device adds sync parity only at length eight
        syncFrame = {s.cfg.parEn & (wlenN == WLEN_MAX) & syncParCalc, s.syncChr};
        if (txTick) begin
            next_s.txPh = txBitEnd ? 5'h00 : s.txPh + 5'h01;
        end
        if (!s.cfg.txEn) begin
            next_s.txSt  = TX_IDLE;
            next_s.txOut = 1'b1;
        end else if (txTick) begin
            case (s.txSt)
                TX_IDLE: begin
                    next_s.txPh  = 5'h00;
                    next_s.txCnt = '0;
                    if (syncMode || s.txFull) begin
                        next_s.txSh   = txFrame;
                        next_s.txFull &= ~s.txFull;
                        intSet[INT_TX_EMPTY] = s.txFull;
                        if (syncMode && !s.txFull) begin
                            next_s.txSh    = syncFrame;
                            next_s.txUnder = 1'b1;
                            intSet[INT_TX_ERR] = 1'b1;
                        end
                        next_s.txSt  = syncMode ? TX_DATA : TX_START;
                        next_s.txOut = syncMode ? next_s.txSh[0] : 1'b0;
                    end
                end
                TX_START: begin
                    if (txBitEnd) begin
                        next_s.txSt  = TX_DATA;
                        next_s.txOut = s.txSh[0];
                    end
                end
                TX_DATA: begin
                    if (txBitEnd) begin
                        next_s.txCnt = txIdx;
                        next_s.txOut = s.txSh[txIdx];
                        if (txIdx == nBits) begin
                            next_s.txCnt = '0;
                            if (syncMode) begin
                                next_s.txSh   = s.txFull ? txFrame : syncFrame;
                                next_s.txFull &= ~s.txFull;
                                next_s.txUnder = s.txUnder | ~s.txFull;
                                intSet[INT_TX_EMPTY] = s.txFull;
                                intSet[INT_TX_ERR]   = ~s.txFull;
                                next_s.txOut  = next_s.txSh[0];
                            end else begin
                                next_s.txSt  = TX_STOP;
                                next_s.txOut = 1'b1;
                            end
                        end
                    end
                end
                TX_STOP: begin
                    if (txBitEnd) begin
                        next_s.txSt = TX_IDLE;
                    end
                end
                default: next_s.txSt = TX_IDLE;
            endcase
        end
        // A new event wins over a read that clears it
        next_s.intSt = (s.intSt & ~intClr) | intSet;
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            s         <= '0;
            s.cfg     <= CFG_RESET;
            s.intSt   <= INT_RESET;
            s.intMask <= MASK_RESET;
            s.rxSt    <= RX_IDLE;
            s.txSt    <= TX_IDLE;
            s.lastSi  <= 1'b1;
            s.txOut   <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign prdata    = s.rdData;
    assign pslverr   = s.rdErr & psel & penable & ~pwrite;
    assign pready    = 1'b1;
    assign serialOut = s.txOut;
    assign irq       = |(s.intSt & s.intMask);
    // masked channels hand over to DMA ready lines
    assign rxReady   = s.bufFull & ~s.intMask[INT_RX_FULL];
    assign txReady   = ~s.txFull & s.cfg.txEn & ~s.intMask[INT_TX_EMPTY];
endmodule

// file: include/sac_pkg.sv
// Constants, register map and types of the serial channel.
// Assumes an APB master with 32-bit data and byte addresses.
package sac_pkg;

    // ----------------------------------------
    // Register byte offsets
    // ----------------------------------------
    localparam logic [7:0] ADDR_CTRL    = 8'h00;
    localparam logic [7:0] ADDR_SYNC    = 8'h04;
    localparam logic [7:0] ADDR_RXSTAT  = 8'h08;
    localparam logic [7:0] ADDR_TXSTAT  = 8'h0C;
    localparam logic [7:0] ADDR_DATA    = 8'h10;
    localparam logic [7:0] ADDR_INTSTAT = 8'h14;
    localparam logic [7:0] ADDR_INTMASK = 8'h18;

    // ----------------------------------------
    // Fields and codes
    // ----------------------------------------
    localparam logic [1:0] STOP_SYNC = 2'h0;
    localparam logic [1:0] STOP_1    = 2'h1;
    localparam logic [1:0] STOP_15   = 2'h2;
    localparam logic [3:0] WLEN_MAX  = 4'h8;
    localparam int INT_RX_FULL  = 0;
    localparam int INT_RX_ERR   = 1;
    localparam int INT_TX_EMPTY = 2;
    localparam int INT_TX_ERR   = 3;
    localparam logic [3:0] INT_RESET  = 4'h0;
    localparam logic [3:0] MASK_RESET = 4'h0;

    // ----------------------------------------
    // Receive and transmit timing, in clock-pin edges
    // ----------------------------------------
    localparam logic [3:0] RX_MID        = 4'h8;
    localparam logic [3:0] RESYNC_MIN    = 4'h4;
    localparam logic [3:0] FS_STABLE     = 4'h3;
    localparam logic [3:0] FS_HOLD       = 4'h8;
    localparam logic [3:0] START_ACCEPT  = FS_STABLE + FS_HOLD;
    localparam logic [3:0] PH16_LAST     = 4'hF;
    localparam logic [4:0] TX_BIT_LAST16 = 5'h0F;
    localparam logic [4:0] TX_STOP15_16  = 5'h17;
    localparam logic [4:0] TX_STOP2_16   = 5'h1F;
    localparam logic [4:0] TX_STOP2_1    = 5'h01;

    typedef struct packed {
        logic       txEn;
        logic       rxEn;
        logic       strip;
        logic       even;
        logic       parEn;
        logic [1:0] stop;
        logic [1:0] wlen;
        logic       div16;
    } sac_cfg_t;

    localparam sac_cfg_t CFG_RESET = '0;

    typedef enum logic [1:0] { RX_IDLE, RX_START, RX_DATA, RX_STOP } sac_rx_state_t;
    typedef enum logic [1:0] { TX_IDLE, TX_START, TX_DATA, TX_STOP } sac_tx_state_t;

endpackage

// file: hw/sac_edge.sv
// Rising-edge detector for a clock pin sampled by mclk.
// Assumes the pin is already synchronous to mclk.
`timescale 1ns/1ps
module sac_edge (
    input  wire logic mclk,
    input  wire logic rstn,
    input  wire logic level,
    output logic      rise
);
    typedef struct packed {
        logic last;
    } sac_edge_state_t;

    sac_edge_state_t s;
    sac_edge_state_t next_s;

    always_comb begin
        next_s.last = level;
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign rise = level & ~s.last;
endmodule

// file: hw/sac_parity.sv
// Parity over the low len bits of a character.
// Purely combinational; len is 5 to 8.
`timescale 1ns/1ps
module sac_parity #(
    parameter int W = 8
) (
    input  wire logic [W-1:0] data,
    input  wire logic [3:0]   len,
    input  wire logic         even,
    output logic              par
);
    logic [W-1:0] used;

    always_comb begin
        for (int i = 0; i < W; i++) begin
            used[i] = data[i] & (4'(i) < len);
        end
        // Even parity bit makes the total count of ones even
        par = even ? ^used : ~^used;
    end
endmodule

// file: dv/sac_serial_channel_chk.sv
// Port-level checker for the serial channel.
// Assumes it is bound to every sac_serial_channel instance.
`timescale 1ns/1ps
module sac_serial_channel_chk
    import sac_pkg::*;
(
    input wire logic        mclk,
    input wire logic        rstn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        txClk,
    input wire logic        serialOut,
    input wire logic        rxReady,
    input wire logic        txReady,
    input wire logic        irq
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    logic rdAcc;
    assign rdAcc = psel && penable && !pwrite;
    ready_const_a: assert property (pready)
        else $error("pready low");
    err_phase_a: assert property (pslverr |-> rdAcc)
        else $error("pslverr outside a read");
    unmap_read_a: assert property (rdAcc && paddr == 8'h1C |-> pslverr && prdata == 32'h0)
        else $error("unmapped read not refused");
    data_ok_a: assert property (rdAcc && paddr == ADDR_DATA |-> !pslverr)
        else $error("data read refused");
    irq_fall_a: assert property ($fell(irq) |-> $past(psel && penable))
        else $error("irq fell without access");
    rx_fall_a: assert property ($fell(rxReady) |-> $past(psel && penable))
        else $error("rxReady fell without access");
    read_clear_a: assert property (rdAcc && paddr == ADDR_DATA && rxReady |=> !rxReady)
        else $error("data read kept buffer full");
    tx_load_a: assert property (psel && penable && pwrite && paddr == ADDR_DATA && txReady
        |=> !txReady)
        else $error("tx write kept txReady");
    out_tick_a: assert property ($changed(serialOut) |-> $past(txClk) || $past(txClk, 2))
        else $error("serialOut moved off a tx tick");
endmodule
bind sac_serial_channel sac_serial_channel_chk sac_serial_channel_chk_inst (.mclk, .rstn,
    .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .txClk, .serialOut,
    .rxReady, .txReady, .irq);

// file: dv/sac_remote.sv
// Remote serial equipment: free bit clock, sends one framed word LSB first.
// Assumes mclk runs eight times the bit clock.
`timescale 1ns/1ps
module sac_remote (
    input  wire logic        mclk,
    input  wire logic        rstn,
    input  wire logic        go,
    input  wire logic [15:0] frame,
    output logic             rxClk,
    output logic             txClk,
    output logic             serialIn,
    output logic             busy
);
    logic [1:0]  div;
    logic [15:0] sh;
    logic [4:0]  cnt;
    assign txClk = rxClk;
    assign busy  = cnt != 5'h0;
    // bits change on the falling clock, stable at the rise
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            div <= 2'h0;
            rxClk <= 1'b0;
            sh <= 16'hFFFF;
            cnt <= 5'h0;
            serialIn <= 1'b1;
        end else begin
            div <= div + 2'h1;
            if (div == 2'h3)
                rxClk <= !rxClk;
            if (div == 2'h3 && rxClk && busy) begin
                serialIn <= sh[0];
                sh <= {1'b1, sh[15:1]};
                cnt <= cnt - 5'h1;
            end
            if (go) begin
                sh <= frame;
                cnt <= 5'h10;
            end
        end
    end
endmodule

// file: dv/sac_serial_channel_test.sv
// Self-checking bench for the serial channel.
// Assumes sac_remote drives the receive pins.
`timescale 1ns/1ps
module sac_serial_channel_test
    import sac_pkg::*;
;
    logic        mclk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, go = 0;
    logic [7:0]  paddr = 0;
    logic [31:0] pwdata = 0, prdata;
    logic        pready, pslverr, rxClk, txClk, serialIn, serialOut, rxReady, txReady, irq, busy;
    logic [15:0] frame = 16'hFFFF;
    logic [32:0] expQ[$];
    int          error_cnt = 0, samples_checked = 0;
    always #5 mclk = ~mclk;
    sac_serial_channel sac_serial_channel_inst (.mclk, .rstn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .rxClk, .txClk, .serialIn(serialIn & serialOut),
        .serialOut, .rxReady, .txReady, .irq);
    sac_remote sac_remote_inst (.mclk, .rstn, .go, .frame, .rxClk, .txClk, .serialIn, .busy);
    task automatic summarize;
        $display("checked %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic fail(input string what);
        error_cnt++;
        $display("mismatch %s expected 1 seen 0", what);
        summarize();
    endtask
    // Watcher: each read answer is matched against the oldest note
    always @(posedge mclk)
        if (psel && penable && !pwrite && pready === 1'b1 && expQ.size() > 0) begin
            logic [32:0] e;
            e = expQ.pop_front();
            samples_checked++;
            if ({pslverr, prdata} !== e) begin
                error_cnt++;
                $display("mismatch read %h expected %h seen %h", paddr, e, {pslverr, prdata});
            end
        end
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1) begin
            @(posedge mclk);
            n++;
            if (n > 50) fail("pready");
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [32:0] e);
        expQ.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask
    // Waits for 0 rxReady, 1 irq, 2 partner idle, 3 txReady
    task automatic waitSig(input int w);
        int n = 0;
        psel <= 1'b0;
        penable <= 1'b0;
        do begin
            @(posedge mclk);
            #1;
            n++;
            if (n > 9000) fail("wait");
        end while ((w == 0 ? rxReady : w == 1 ? irq : w == 2 ? !busy : txReady) !== 1'b1);
        @(posedge mclk);
    endtask
    task automatic send(input logic [15:0] f);
        waitSig(2);
        frame <= f;
        go <= 1'b1;
        @(posedge mclk);
        go <= 1'b0;
    endtask
    // Frame with start bit at bit 0; upper byte is the stored character
    function automatic logic [23:0] mk(input logic [7:0] d, input int len, input bit ev,
                                       input bit bad);
        logic [7:0]  m = d & (8'hFF >> (8 - len));
        logic        p = (^m) ^ !ev ^ bad;
        logic [15:0] f = (16'hFFFF << (len + 1)) | {7'h0, m, 1'b0};
        f[len + 1] = p;
        return {len < 8 ? m | (8'(p) << len) : m, f};
    endfunction
    initial begin
        logic [23:0] c;
        logic [23:0] c2;
        void'($urandom(5));
        repeat (5) @(posedge mclk);
        rstn <= 1'b1;
        @(posedge mclk);
        rd(ADDR_CTRL, 33'h0);
        rd(ADDR_INTMASK, 33'h0);
        rd(8'h1C, {1'b1, 32'h0});
        $display("test reset done");
        for (int i = 0; i < 4; i++) begin
            c = mk(8'($urandom), 8 - i, i[0], 1'b0);
            apb(1'b1, ADDR_CTRL, 32'h128 | 32'(i << 1) | (32'(i[0]) << 6));
            apb(1'b1, ADDR_INTMASK, 32'h0);
            send(c[15:0]);
            waitSig(0);
            rd(ADDR_RXSTAT, 33'h1);
            rd(ADDR_DATA, 33'(c[23:16]));
            rd(ADDR_INTSTAT, 33'h1);
        end
        $display("test word lengths done");
        c = mk(8'h5A, 8, 1'b1, 1'b1);
        apb(1'b1, ADDR_CTRL, 32'h168);
        apb(1'b1, ADDR_INTMASK, 32'h3);
        send(c[15:0]);
        waitSig(1);
        rd(ADDR_RXSTAT, 33'h3);
        rd(ADDR_DATA, 33'h5A);
        rd(ADDR_INTSTAT, 33'h3);
        rd(ADDR_INTSTAT, 33'h0);
        apb(1'b1, ADDR_INTMASK, 32'h0);
        c = mk(8'($urandom), 8, 1'b1, 1'b0);
        c2 = mk(8'($urandom), 8, 1'b1, 1'b1);
        send(c[15:0]);
        send(c2[15:0]);
        waitSig(2);
        rd(ADDR_RXSTAT, 33'h1);
        rd(ADDR_DATA, 33'(c[23:16]));
        waitSig(0);
        rd(ADDR_RXSTAT, 33'h3);
        rd(ADDR_DATA, 33'(c2[23:16]));
        $display("test receive done");
        for (int s = 1; s < 4; s++) begin
            apb(1'b1, ADDR_CTRL, 32'h300 | 32'(s << 3 | s & 1));
            waitSig(3);
            c = 24'($urandom);
            apb(1'b1, ADDR_DATA, 32'(c[7:0]));
            waitSig(3);
            waitSig(0);
            rd(ADDR_DATA, 33'(c[7:0]));
        end
        $display("test transmit done");
        summarize();
    end
endmodule
